// ### design/system_event_router.sv
`default_nettype none
module system_event_router #(
    parameter int NUM_MASKABLE = event_router_pkg::NUM_MASKABLE
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              resetn,
    // Event sources
    input  wire event_router_pkg::periph_event_type periph,
    input  wire event_router_pkg::core_event_type   core,
    // Routing configuration
    input  wire logic [NUM_MASKABLE-1:0][6:0]      cpu_input_select,
    input  wire logic [3:0][31:0]                  combiner_mask,
    input  wire logic [127:0]                      exception_enable,
    input  wire logic [127:0]                      emulation_enable,
    // Processor side
    output logic [NUM_MASKABLE-1:0]                maskable_cpu_input,
    output logic                                   cpu_exception_input,
    output logic                                   emulation_event_out,
    output logic [3:0]                             combined_event
);
    import event_router_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Refuse more maskable inputs than the core offers
    if (NUM_MASKABLE < 1 || NUM_MASKABLE > 12) begin
        $error("NUM_MASKABLE must be 1 to 12");
    end

    // Any unmasked event within one combiner group
    function automatic logic comb_any(
        input logic [31:0] ev,
        input logic [31:0] msk
    );
        return |(ev & ~msk);
    endfunction

    logic [127:0]            raw_nxt;
    logic [127:0]            level_r;
    logic [127:0]            level_nxt;
    logic [127:0]            pulse_r;
    logic [127:0]            pulse_nxt;
    logic [NUM_MASKABLE-1:0] cpu_r;
    logic [NUM_MASKABLE-1:0] cpu_nxt;
    logic                    exc_r;
    logic                    exc_nxt;
    logic                    emu_r;
    logic                    emu_nxt;

    // Assemble the numbered event vector from both source groups
    always_comb begin
        raw_nxt = periph.misc & PERIPH_EVENT_MASK;
        raw_nxt[EVT_ETH_GENERAL] =
            periph.ethernet_general_event;
        raw_nxt[EVT_ETH_RECEIVE] =
            periph.ethernet_receive_event;
        raw_nxt[EVT_ETH_TRANSMIT] =
            periph.ethernet_transmit_event;
        raw_nxt[EVT_ETH_RX_THR] =
            periph.ethernet_rx_threshold_event;
        raw_nxt[EVT_DMA_DONE] =
            periph.dma_global_completion_event;
        raw_nxt[127:96] = core.misc & CORE_EVENT_MASK[127:96];
        raw_nxt[EVT_EMULATION] = core.emulation_event;
        raw_nxt[EVT_DX_RECEIVE] =
            core.data_exchange_receive_event;
        raw_nxt[EVT_DX_TRANSMIT] =
            core.data_exchange_transmit_event;
        raw_nxt[EVT_IDMA_CH0] =
            core.internal_dma_channel0_event;
        raw_nxt[EVT_IDMA_CH1] =
            core.internal_dma_channel1_event;
        // Unwired and reserved numbers are tied low
        raw_nxt = raw_nxt & CONNECTED_MASK;
        raw_nxt = raw_nxt & ~RESERVED_EVENT_MASK;
        raw_nxt[3:0] = 4'h0;
    end

    // Combiners drive events 0..3; rising edges become pulses
    always_comb begin
        level_nxt = raw_nxt;
        for (int c = 0; c < NUM_COMBINERS; c++) begin
            level_nxt[c] = comb_any(
                raw_nxt[c*COMB_WIDTH +: COMB_WIDTH],
                combiner_mask[c]);
        end
        pulse_nxt = level_nxt & ~level_r;
    end

    // Event level and pulse registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_r <= '0;
            pulse_r <= '0;
        end else begin
            level_r <= level_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // Select one event per maskable input; OR-in exception and emulation
    always_comb begin
        for (int i = 0; i < NUM_MASKABLE; i++) begin
            cpu_nxt[i] = pulse_r[cpu_input_select[i]];
        end
        exc_nxt = |(pulse_r & exception_enable);
        emu_nxt = |(pulse_r & emulation_enable);
    end

    // Output registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_r <= '0;
            exc_r <= 1'b0;
            emu_r <= 1'b0;
        end else begin
            cpu_r <= cpu_nxt;
            exc_r <= exc_nxt;
            emu_r <= emu_nxt;
        end
    end

    // Outputs straight from flops
    assign maskable_cpu_input  = cpu_r;
    assign cpu_exception_input = exc_r;
    assign emulation_event_out = emu_r;
    assign combined_event      = level_r[3:0];

    // Each maskable input follows its selected pulse, one edge late
    for (genvar g = 0; g < NUM_MASKABLE; g++) begin : g_route
        AST_ROUTE: assert property (
            ##1 maskable_cpu_input[g] ==
                $past(pulse_r[cpu_input_select[g]])
        ) else $error("maskable input does not follow its event");

        AST_NO_UNWIRED: assert property (
            maskable_cpu_input[g] |->
                CONNECTED_MASK[$past(cpu_input_select[g])]
        ) else $error("unwired event reached a maskable input");

        AST_DMA_ROUTED: assert property (
            $rose(periph.dma_global_completion_event) &&
            cpu_input_select[g] == 7'(EVT_DMA_DONE) |-> ##2
                maskable_cpu_input[g]
        ) else $error("dma completion did not reach its input");
    end

    // Exception and emulation follow their enabled pulses
    AST_EXCEPTION: assert property (
        ##1 cpu_exception_input ==
            $past(|(pulse_r & exception_enable))
    ) else $error("exception input mismatch");

    AST_EMULATION: assert property (
        |(pulse_r & emulation_enable) |=> emulation_event_out
    ) else $error("emulation output missed an event");

    // Combiners 0 and 1 track their unmasked ranges
    AST_COMB_LOW: assert property (
        ##1 combined_event[1:0] == $past({
            |(raw_nxt[63:32] & ~combiner_mask[1]),
            |(raw_nxt[31:1] & ~combiner_mask[0][31:1])})
    ) else $error("combiner 0 or 1 wrong");

    // Combiners 2 and 3 track their unmasked ranges
    AST_COMB_HIGH: assert property (
        ##1 combined_event[3:2] == $past({
            |(raw_nxt[127:96] & ~combiner_mask[3]),
            |(raw_nxt[95:64] & ~combiner_mask[2])})
    ) else $error("combiner 2 or 3 wrong");

    // Unwired and reserved numbers never go active
    AST_UNWIRED: assert property (
        (level_r & ~CONNECTED_MASK) == '0 &&
        (level_r & RESERVED_EVENT_MASK) == '0
    ) else $error("unwired event went active");

    // Upper core events come from the core side only
    AST_CORE_SIDE: assert property (
        ##1 level_r[127:97] == $past(
            core.misc[31:1] & CORE_EVENT_MASK[127:97])
    ) else $error("core event group mismatch");

    // Ethernet sources sit on their fixed numbers
    AST_ETHERNET: assert property (
        ##1 {level_r[EVT_ETH_GENERAL], level_r[EVT_ETH_RECEIVE],
             level_r[EVT_ETH_TRANSMIT], level_r[EVT_ETH_RX_THR]}
        == $past({periph.ethernet_general_event,
                  periph.ethernet_receive_event,
                  periph.ethernet_transmit_event,
                  periph.ethernet_rx_threshold_event})
    ) else $error("ethernet event misplaced");

    // DMA completion rises on its own number
    AST_DMA_DONE: assert property (
        $rose(periph.dma_global_completion_event) |=>
            pulse_r[EVT_DMA_DONE]
    ) else $error("dma completion pulse missing");

    // Data exchange events
    AST_DATA_EXCHANGE: assert property (
        ##1 level_r[EVT_DX_TRANSMIT:EVT_DX_RECEIVE] == $past({
            core.data_exchange_transmit_event,
            core.data_exchange_receive_event})
    ) else $error("data exchange event misplaced");

    // Internal DMA channel events
    AST_INTERNAL_DMA: assert property (
        ##1 level_r[EVT_IDMA_CH1:EVT_IDMA_CH0] == $past({
            core.internal_dma_channel1_event,
            core.internal_dma_channel0_event})
    ) else $error("internal dma event misplaced");

    // A pulse never lasts two cycles on the same event
    AST_SINGLE_PULSE: assert property (
        ##1 (pulse_r & $past(pulse_r)) == '0
    ) else $error("event pulse longer than one cycle");

    // A held DMA completion event gives exactly one pulse
    AST_HELD_ONCE: assert property (
        pulse_r[EVT_DMA_DONE] ##1 level_r[EVT_DMA_DONE] |->
            !pulse_r[EVT_DMA_DONE]
    ) else $error("held event pulsed twice");

    // Exception stays low when no enabled pulse was seen
    AST_EXC_QUIET: assert property (
        (pulse_r & exception_enable) == '0 |=>
            !cpu_exception_input
    ) else $error("exception input pulsed with no event");

    // Emulation stays low when no enabled pulse was seen
    AST_EMU_QUIET: assert property (
        (pulse_r & emulation_enable) == '0 |=>
            !emulation_event_out
    ) else $error("emulation output pulsed with no event");

    // A pulse marks exactly the rising edges of event levels
    AST_PULSE_EDGE: assert property (
        ##1 pulse_r == (level_r & ~$past(level_r))
    ) else $error("event pulse not on a rising edge");

    // No pulse ever appears on an unwired number
    AST_PULSE_WIRED: assert property (
        (pulse_r & ~CONNECTED_MASK) == '0
    ) else $error("unwired event pulsed");

    // Emulation source sits on its own number
    AST_EMU_SOURCE: assert property (
        ##1 level_r[EVT_EMULATION] == $past(core.emulation_event)
    ) else $error("emulation source misplaced");

    // Peripheral numbers 32..95 follow the chip-level lines
    AST_PERIPH_SIDE: assert property (
        ##1 level_r[95:32] == $past(
            periph.misc[95:32] & PERIPH_EVENT_MASK[95:32])
    ) else $error("peripheral event group mismatch");

    // Reserved numbers never go active or pulse
    AST_RESERVED: assert property (
        (level_r & RESERVED_EVENT_MASK) == '0 &&
        (pulse_r & RESERVED_EVENT_MASK) == '0
    ) else $error("reserved event went active");

    // Each maskable input pulses for one cycle only
    AST_OUT_SINGLE: assert property (
        ##1 (maskable_cpu_input & $past(maskable_cpu_input)) == '0
    ) else $error("maskable input held longer than one cycle");

    // Combiner pulse follows the rise of its level
    AST_COMB_PULSE: assert property (
        ##1 pulse_r[3:0] == (combined_event & ~$past(combined_event))
    ) else $error("combiner pulse mismatch");

    // Combiner 0 stays low while its whole range is masked
    AST_COMB_MASKED: assert property (
        combiner_mask[0][31:1] == '1 |=> !combined_event[0]
    ) else $error("masked combiner 0 went active");

    // Ethernet receive rises to a pulse on its number
    AST_ETH_PULSE: assert property (
        $rose(periph.ethernet_receive_event) |=>
            pulse_r[EVT_ETH_RECEIVE]
    ) else $error("ethernet receive pulse missing");

    // Transmit completion of the data exchange pulses too
    AST_DX_TX_PULSE: assert property (
        $rose(core.data_exchange_transmit_event) |=>
            pulse_r[EVT_DX_TRANSMIT]
    ) else $error("data exchange transmit pulse missing");

    // Internal DMA channel 0 rises to a pulse on its number
    AST_IDMA_PULSE: assert property (
        $rose(core.internal_dma_channel0_event) |=>
            pulse_r[EVT_IDMA_CH0]
    ) else $error("internal dma channel 0 pulse missing");

endmodule
`default_nettype wire

// ### design/event_router_pkg.sv
`default_nettype none
package event_router_pkg;

    // Event space and combiner geometry
    localparam int NUM_EVENTS               = 128;
    localparam int NUM_COMBINERS            = 4;
    localparam int COMB_WIDTH               = 32;
    localparam int EVENT_IDX_W              = 7;
    localparam int MASKABLE_CPU_INPUT_FIRST = 4;
    localparam int MASKABLE_CPU_INPUT_LAST  = 15;
    localparam int NUM_MASKABLE             =
        MASKABLE_CPU_INPUT_LAST - MASKABLE_CPU_INPUT_FIRST + 1;

    // Fixed event numbers
    localparam int EVT_EMULATION    = 9;
    localparam int EVT_DX_RECEIVE   = 11;
    localparam int EVT_DX_TRANSMIT  = 12;
    localparam int EVT_IDMA_CH0     = 13;
    localparam int EVT_IDMA_CH1     = 14;
    localparam int EVT_ETH_GENERAL  = 17;
    localparam int EVT_DMA_DONE     = 24;
    localparam int EVT_ETH_RECEIVE  = 25;
    localparam int EVT_ETH_TRANSMIT = 26;
    localparam int EVT_ETH_RX_THR   = 27;
    localparam int EVT_CORE_HIGH    = 96;

    // Which numbers are wired, and from which side
    localparam logic [127:0] CORE_EVENT_MASK =
        128'hfff20033_00000000_00000000_00007a0f;
    localparam logic [127:0] PERIPH_EVENT_MASK =
        128'h00000000_c0feffff_fff80f17_7ff78000;
    localparam logic [127:0] RESERVED_EVENT_MASK =
        128'h00000000_00000000_0007f000_00000000;
    localparam logic [127:0] CONNECTED_MASK =
        CORE_EVENT_MASK | PERIPH_EVENT_MASK;

    // Chip-level sources; misc carries the other numbers in PERIPH_EVENT_MASK
    typedef struct packed {
        logic         ethernet_general_event;
        logic         ethernet_receive_event;
        logic         ethernet_transmit_event;
        logic         ethernet_rx_threshold_event;
        logic         dma_global_completion_event;
        logic [127:0] misc;
    } periph_event_type;

    // Sources inside the processor subsystem; misc is events 96..127
    typedef struct packed {
        logic        emulation_event;
        logic        data_exchange_receive_event;
        logic        data_exchange_transmit_event;
        logic        internal_dma_channel0_event;
        logic        internal_dma_channel1_event;
        logic [31:0] misc;
    } core_event_type;

endpackage
`default_nettype wire

// ### sim/cpu_core_model.sv
`default_nettype none
module cpu_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Router outputs
    input  wire logic [11:0] maskable_cpu_input,
    input  wire logic        cpu_exception_input,
    input  wire logic        emulation_event_out,
    // Interrupts taken by the core in the last cycle
    output logic      [13:0] taken
);
    timeunit 1ns;
    timeprecision 1ns;

    // Take each input pulse as the core would, one cycle per pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            taken <= 14'h0;
        end else begin
            taken <= {emulation_event_out, cpu_exception_input,
                      maskable_cpu_input};
        end
    end
endmodule
`default_nettype wire

// ### sim/test_system_event_router.sv
`default_nettype none
module test_system_event_router import event_router_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    // Stimulus, outputs and bookkeeping
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    periph_event_type  periph;
    core_event_type    core;
    logic [11:0][6:0]  sel;
    logic [3:0][31:0]  cmask;
    logic [127:0]      exc_en;
    logic [127:0]      emu_en;
    logic [11:0]       mcpu;
    logic              exc;
    logic              emu;
    logic [3:0]        comb;
    logic [13:0]       taken;
    logic [13:0]       exp_q[$];
    int                fail_count = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    int                seed = 32'h09aa41cd;
    int                tbl[12] = '{24, 17, 25, 26, 27, 11, 12, 13, 14, 1, 0, 3};
    int                srcs[15] = '{24, 17, 25, 26, 27, 9, 11, 12, 13, 14,
                                    40, 100, 5, 44, 99};

    always #5 clk = ~clk;

    system_event_router dut (
        .clk                 (clk),
        .resetn              (resetn),
        .periph              (periph),
        .core                (core),
        .cpu_input_select    (sel),
        .combiner_mask       (cmask),
        .exception_enable    (exc_en),
        .emulation_enable    (emu_en),
        .maskable_cpu_input  (mcpu),
        .cpu_exception_input (exc),
        .emulation_event_out (emu),
        .combined_event      (comb)
    );

    cpu_core_model core_side (
        .clk                 (clk),
        .resetn              (resetn),
        .maskable_cpu_input  (mcpu),
        .cpu_exception_input (exc),
        .emulation_event_out (emu),
        .taken               (taken)
    );

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Closing report
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Event above 3 feeds its combiner when wired and unmasked
    function automatic logic comb_hit(input int e);
        return CONNECTED_MASK[e] && e > 3 && !cmask[e/32][e%32];
    endfunction

    // Outputs expected from one occurrence of event e
    function automatic logic [13:0] expect_word(input int e);
        logic [13:0] w;
        int          c;
        w = 14'h0;
        c = e / 32;
        if (!CONNECTED_MASK[e])
            return w;
        for (int i = 0; i < 12; i++)
            w[i] = (sel[i] == e) || (comb_hit(e) && sel[i] == c);
        w[12] = exc_en[e] | (comb_hit(e) & exc_en[c]);
        w[13] = emu_en[e] | (comb_hit(e) & emu_en[c]);
        return w;
    endfunction

    // Drive one source level, with noise on every unwired line
    task automatic set_src(input int e, input logic v);
        periph.misc = (periph.misc & PERIPH_EVENT_MASK)
                    | ({4{$random(seed)}} & ~PERIPH_EVENT_MASK);
        core.misc = (core.misc & CORE_EVENT_MASK[127:96])
                  | ($random(seed) & ~CORE_EVENT_MASK[127:96]);
        case (e)
            17: periph.ethernet_general_event = v;
            24: periph.dma_global_completion_event = v;
            25: periph.ethernet_receive_event = v;
            26: periph.ethernet_transmit_event = v;
            27: periph.ethernet_rx_threshold_event = v;
            9: core.emulation_event = v;
            11: core.data_exchange_receive_event = v;
            12: core.data_exchange_transmit_event = v;
            13: core.internal_dma_channel0_event = v;
            14: core.internal_dma_channel1_event = v;
            default: begin
                if (e >= 96)
                    core.misc[e-96] = v;
                else
                    periph.misc[e] = v;
            end
        endcase
    endtask

    // One occurrence: raise, hold three cycles, drop, stay quiet
    task automatic fire(input int e);
        logic [13:0] w;
        w = expect_word(e);
        @(negedge clk);
        set_src(e, 1'b1);
        if (w !== 14'h0)
            exp_q.push_back(w);
        repeat (2) @(posedge clk);
        #1 check(comb, comb_hit(e) ? (4'h1 << (e / 32)) : 4'h0);
        repeat (2) @(negedge clk);
        set_src(e, 1'b0);
        repeat (4) @(negedge clk);
        check(exp_q.size(), 0);
    endtask

    // Pair each pulse the core took with the oldest expectation
    always @(negedge clk) begin
        if (resetn && taken !== 14'h0) begin
            if (exp_q.size() == 0)
                check(taken, 14'h0);
            else
                check(taken, exp_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 2000) begin
            fail_count++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        periph = '0;
        core = '0;
        cmask = '0;
        exc_en = '0;
        emu_en = '0;
        for (int i = 0; i < 12; i++)
            sel[i] = 7'(tbl[i]);
        repeat (20) @(posedge clk);
        #1 check(comb, 4'h0);
        @(negedge clk);
        resetn = 1'b1;
        for (int r = 0; r < 2; r++) begin
            exc_en = {4{$random(seed)}};
            emu_en = {4{$random(seed)}};
            if (r > 0)
                cmask = {4{$random(seed)}};
            foreach (srcs[k])
                fire(srcs[k]);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
